//--- rtl/bridge_ctrl_pkg.sv
package bridge_ctrl_pkg;
  // address byte: [7] direction, [6:2] register code, [1] qualifier, [0] always one
  localparam int unsigned DIR_BIT        = 7;
  localparam int unsigned CODE_MSB       = 6;
  localparam int unsigned CODE_LSB       = 2;
  localparam int unsigned QUAL_BIT       = 1;
  localparam int unsigned FRAME_BITS     = 16;
  localparam logic [4:0]  CODE_SW_LOW    = 5'h00; // code of the low switch group
  localparam logic [4:0]  CODE_SW_HIGH   = 5'h10; // 100 00
  localparam logic [4:0]  CODE_PWM_LOW   = 5'h18; // 110 00
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [1:0]  MODE_CONT      = 2'h0;
  localparam int unsigned SCLK_HALF_CYC  = 4;     // serial clock half period in clk_sys cycles
  // host apb offsets
  localparam logic [7:0]  OFS_CMD        = 8'h00;
  localparam logic [7:0]  OFS_STAT       = 8'h04;
  localparam logic [7:0]  OFS_RDATA      = 8'h08;
  localparam int unsigned CMD_GO_BIT     = 16;

  // builds the address byte from direction and register code
  function automatic logic [7:0] addr_byte(input logic wr, input logic [4:0] code);
    return {wr, code, 1'b0, 1'b1};
  endfunction
endpackage

//--- rtl/bridge_link_if.sv
`timescale 1ns/1ps
interface bridge_link_if;
  logic sclk;
  logic csn;
  logic mosi;
  logic miso;
  modport host   (output sclk, output csn, output mosi, input miso);
  modport device (input sclk, input csn, input mosi, output miso);
endinterface

//--- rtl/bridge_ctrl_regs.sv
`timescale 1ns/1ps
// Behaviour
// - all control registers reset to zero
// - command is address byte then data
// - only host writes change registers
// - direction bit zero reads, no change
// - direction bit one writes data byte
// - low switch group: bridge4 high at 7
// - high switch group: bridge8 high at 7
// - zero keeps switch off, one on
// - both enables set turn bridge off
// - mode 00 continuous, else pwm channel
// - pwm select fields bridge4 to bridge1
// - address byte carries code and qualifier
module bridge_ctrl_regs (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  bridge_link_if.device    link,
  input  wire logic [2:0]  pwm_wave,
  output logic      [7:0]  high_side_switch,
  output logic      [7:0]  low_side_switch
);
  import bridge_ctrl_pkg::*;

  typedef struct packed {
    logic [2:0]  sclk_s;    // two-flop sync plus edge history
    logic [1:0]  csn_s;
    logic [1:0]  mosi_s;
    logic [15:0] shift;
    logic [4:0]  count;
    logic [7:0]  tx;
    logic        miso;
    logic [7:0]  sw_low;
    logic [7:0]  sw_high;
    logic [7:0]  pwm_low;
    logic [7:0]  hs;
    logic [7:0]  ls;
  } dev_state_t;

  dev_state_t st_r, st_nxt;
  logic [2:0] pwm_s1_r, pwm_s2_r;

  // pwm waves come from elsewhere, so synchronise them
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwm_s1_r <= 3'h0;
      pwm_s2_r <= 3'h0;
    end else begin
      pwm_s1_r <= pwm_wave;
      pwm_s2_r <= pwm_s1_r;
    end
  end

  function automatic logic [7:0] reg_read(input logic [4:0] code, input dev_state_t s);
    case (code)
      CODE_SW_LOW:  return s.sw_low;
      CODE_SW_HIGH: return s.sw_high;
      CODE_PWM_LOW: return s.pwm_low;
      default:      return 8'h00;
    endcase
  endfunction

  always_comb begin
    logic rise;
    logic fall;
    logic [15:0] frame;
    logic on;
    logic [1:0] mode;
    rise  = 1'b0;
    fall  = 1'b0;
    frame = 16'h0000;
    on    = 1'b0;
    mode  = MODE_CONT;
    st_nxt = st_r;
    st_nxt.sclk_s = {st_r.sclk_s[1:0], link.sclk};
    st_nxt.csn_s  = {st_r.csn_s[0], link.csn};
    st_nxt.mosi_s = {st_r.mosi_s[0], link.mosi};
    rise = st_r.sclk_s[1] & ~st_r.sclk_s[2];
    fall = ~st_r.sclk_s[1] & st_r.sclk_s[2];
    // frame ends or idle: drop partial frames, nothing stored
    if (st_r.csn_s[1]) begin
      st_nxt.count = 5'h00;
      st_nxt.miso  = 1'b0;
    end else if (rise) begin
      frame = {st_r.shift[14:0], st_r.mosi_s[1]};
      st_nxt.shift = frame;
      st_nxt.count = st_r.count + 5'h01;
      if (st_r.count == 5'h07) // address byte complete: load read data
        st_nxt.tx = reg_read(frame[CODE_LSB +: 5], st_r);
      if (st_r.count == 5'(FRAME_BITS - 1) && frame[8+DIR_BIT]) begin
        case (frame[8+CODE_LSB +: 5])
          CODE_SW_LOW:  st_nxt.sw_low  = frame[7:0];
          CODE_SW_HIGH: st_nxt.sw_high = frame[7:0];
          CODE_PWM_LOW: st_nxt.pwm_low = frame[7:0];
          default: ;
        endcase
      end // a read leaves the bank alone
    end else if (fall && st_r.count >= 5'h08) begin
      st_nxt.miso = st_r.tx[7];
      st_nxt.tx   = {st_r.tx[6:0], 1'b0};
    end
    // switch drive with cross-current block and pwm gating
    for (int i = 0; i < 8; i++) begin
      logic h, l;
      h = (i < 4) ? st_r.sw_low[2*i+1] : st_r.sw_high[2*(i-4)+1];
      l = (i < 4) ? st_r.sw_low[2*i]   : st_r.sw_high[2*(i-4)];
      mode = (i < 4) ? st_r.pwm_low[2*i +: 2] : MODE_CONT;
      on = (mode == MODE_CONT) ? 1'b1 : pwm_s2_r[mode - 2'h1];
      st_nxt.hs[i] = h & ~l & on;
      st_nxt.ls[i] = l & ~h & on;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r         <= '0;
      st_r.sclk_s  <= 3'h0;
      st_r.csn_s   <= 2'h3;
      st_r.sw_low  <= CTRL_RESET;
      st_r.sw_high <= CTRL_RESET;
      st_r.pwm_low <= CTRL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.miso        = st_r.miso;
  assign high_side_switch = st_r.hs;
  assign low_side_switch  = st_r.ls;
endmodule // bridge_ctrl_regs

//--- rtl/bridge_ctrl_host.sv
`timescale 1ns/1ps
// apb-driven serial host that sends one 16-bit command per go
module bridge_ctrl_host (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  bridge_link_if.host      link
);
  import bridge_ctrl_pkg::*;

  typedef enum logic [1:0] {IDLE, SHIFT, DONE} hstate_t;
  typedef struct packed {
    hstate_t     fsm;
    logic [15:0] tx;
    logic [7:0]  rx;
    logic [4:0]  bits;
    logic [2:0]  div;
    logic        sclk;
    logic        csn;
    logic        mosi;
    logic [1:0]  miso_s;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } host_state_t;

  host_state_t st_r, st_nxt;

  always_comb begin
    logic acc;
    acc = psel & penable & ~st_r.pready;
    st_nxt = st_r;
    st_nxt.miso_s = {st_r.miso_s[0], link.miso};
    st_nxt.pready = acc;
    st_nxt.pslverr = 1'b0;
    // register access, one wait state
    if (acc) begin
      case (paddr)
        OFS_CMD: begin
          if (pwrite && pwdata[CMD_GO_BIT] && st_r.fsm == IDLE) begin
            st_nxt.tx   = pwdata[15:0];
            st_nxt.fsm  = SHIFT;
            st_nxt.csn  = 1'b0;
            st_nxt.bits = 5'h00;
            st_nxt.div  = 3'h0;
            st_nxt.mosi = pwdata[15];
          end
          st_nxt.prdata = {16'h0000, st_r.tx};
        end
        OFS_STAT:  st_nxt.prdata = {31'h0, st_r.fsm != IDLE};
        OFS_RDATA: st_nxt.prdata = {24'h000000, st_r.rx};
        default: begin
          st_nxt.prdata  = 32'h00000000;
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
    // serial engine: mode 0, msb first
    case (st_r.fsm)
      IDLE: ;
      SHIFT: begin
        st_nxt.div = st_r.div + 3'h1;
        if (st_r.div == 3'(SCLK_HALF_CYC - 1)) begin
          st_nxt.div  = 3'h0;
          st_nxt.sclk = ~st_r.sclk;
          if (st_r.sclk) begin
            // sample on the fall: device answer needs sync time both ways
            st_nxt.rx   = {st_r.rx[6:0], st_r.miso_s[1]};
            st_nxt.bits = st_r.bits + 5'h01;
            st_nxt.tx   = {st_r.tx[14:0], 1'b0};
            st_nxt.mosi = st_r.tx[14];
            if (st_r.bits == 5'(FRAME_BITS - 1))
              st_nxt.fsm = DONE;
          end
        end
      end
      DONE: begin
        st_nxt.div = st_r.div + 3'h1;
        if (st_r.div == 3'(SCLK_HALF_CYC - 1)) begin
          st_nxt.csn = 1'b1;
          st_nxt.fsm = IDLE;
        end
      end
      default: st_nxt.fsm = IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r     <= '0;
      st_r.fsm <= IDLE;
      st_r.csn <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.sclk = st_r.sclk;
  assign link.csn  = st_r.csn;
  assign link.mosi = st_r.mosi;
  assign prdata    = st_r.prdata;
  assign pready    = st_r.pready;
  assign pslverr   = st_r.pslverr;
endmodule // bridge_ctrl_host

//--- verification/bridge_link_props.sv
`timescale 1ns/1ps
module bridge_link_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csn,
  input wire logic mosi,
  input wire logic miso
);
  logic [4:0] rises_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // serial rises seen in the open frame
  always_ff @(posedge clk_sys) begin
    if (!rst_n || csn) rises_r <= 5'h00;
    else if ($rose(sclk)) rises_r <= rises_r + 5'h01;
  end
  sequence half_high; sclk[*4] ##1 !sclk; endsequence
  sequence frame_open; $fell(csn) ##[1:8] $rose(sclk); endsequence
  a_reset_idle: assert property ($rose(rst_n) |-> csn && !sclk)
    else $error("link not idle after reset");
  a_frame_len: assert property ($rose(csn) |-> rises_r == 5'h10)
    else $error("frame not sixteen bits");
  a_sclk_half: assert property ($rose(sclk) |-> half_high)
    else $error("serial clock half period off");
  a_frame_start: assert property ($fell(csn) |-> frame_open)
    else $error("frame opened without clock");
  a_sclk_idle: assert property (csn && $past(csn) |-> !sclk)
    else $error("serial clock runs outside frame");
  a_mosi_held: assert property (!csn && sclk |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_miso_quiet: assert property (csn && $past(csn) && $past(csn, 2) && $past(csn, 3) |-> !miso)
    else $error("device data outside frame");
  a_miso_edge: assert property ($changed(miso) |-> !sclk)
    else $error("device data moved on rise");
endmodule // bridge_link_props

//--- verification/half_bridge_control_registers_bench.sv
`timescale 1ns/1ps
module half_bridge_control_registers_bench;
  import bridge_ctrl_pkg::*;
  logic        clk_sys, rst_n, psel, penable, pwrite, chk_r, snap_r, pready, pslverr;
  logic [7:0]  paddr, hs, ls;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  pwm_wave, pw;
  logic [32:0] exp_q[$];
  logic [7:0]  rg[3];
  logic [4:0]  codes[3] = '{CODE_SW_LOW, CODE_SW_HIGH, CODE_PWM_LOW};
  int          miscompares, n_tests;
  bridge_link_if link ();
  bridge_ctrl_host u_bridge_ctrl_host (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.host));
  bridge_ctrl_regs u_bridge_ctrl_regs (.clk_sys(clk_sys), .rst_n(rst_n), .link(link.device),
    .pwm_wave(pwm_wave), .high_side_switch(hs), .low_side_switch(ls));
  bridge_link_props u_bridge_link_props (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(link.sclk),
    .csn(link.csn), .mosi(link.mosi), .miso(link.miso));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer; waits for pready however long it takes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk_r <= c;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one serial command, then poll busy so no go is dropped
  task automatic frame(input logic w, input int k, input logic [7:0] d);
    apb(1'b1, OFS_CMD, {15'h0000, 1'b1, addr_byte(w, codes[k]), d}, 1'b0);
    do apb(1'b0, OFS_STAT, 32'h0, 1'b0); while (rd[0] !== 1'b0);
  endtask
  // read-only frame with junk data, so a wrongly stored byte shows up
  task automatic rd_reg(input int k);
    frame(1'b0, k, 8'($urandom));
    exp_q.push_back({25'h0, rg[k]});
    apb(1'b0, OFS_RDATA, 32'h0, 1'b1);
  endtask
  // expected {high, low} switch levels from the shadow registers
  function automatic logic [15:0] sw_exp(input logic [2:0] w);
    logic [15:0] e;
    logic [1:0]  m;
    logic        h, l, g;
    for (int i = 0; i < 8; i++) begin
      h = i < 4 ? rg[0][2*i+1] : rg[1][2*i-7];
      l = i < 4 ? rg[0][2*i] : rg[1][2*i-8];
      m = i < 4 ? rg[2][2*i+:2] : 2'h0;
      g = (m == 2'h0) || w[m-2'h1];
      e[i+8] = h & ~l & g;
      e[i] = l & ~h & g;
    end
    return e;
  endfunction
  // result watcher: oldest note against each checked result
  always @(posedge clk_sys) begin
    if ((psel && penable && pready && !pwrite && chk_r) || snap_r) begin
      n_tests++;
      if (exp_q.size() == 0 || exp_q[0] !== (snap_r ? {17'h0, hs, ls} : {pslverr, prdata})) begin
        miscompares++;
        $display("wrong value at %0t: result differs from expected", $time);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, chk_r, snap_r, paddr, pwdata, pwm_wave} = '0;
    rg = '{default: 8'h00};
    void'($urandom(51));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int k = 0; k < 3; k++) rd_reg(k);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h0c, 32'h0, 1'b1);
    for (int n = 0; n < 8; n++) begin
      for (int k = 0; k < 3; k++) begin
        rg[k] = (n == 0) ? 8'hff : 8'($urandom);
        frame(1'b1, k, rg[k]);
      end
      pw = 3'($urandom);
      pwm_wave <= pw;
      repeat (8) @(posedge clk_sys);
      exp_q.push_back({17'h0, sw_exp(pw)});
      snap_r <= 1'b1;
      @(posedge clk_sys);
      snap_r <= 1'b0;
      for (int k = 0; k < 3; k++) rd_reg(k);
    end
    test_done();
  end
  // hang guard, well beyond the expected run
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
endmodule // half_bridge_control_registers_bench
